/* bench/gprr_rcvr_model.sv */
/*
  gprr_rcvr_model: behavioural receiver on the framed byte link of the relay.
  Assumes valid/ready on the relay's transmit side and a one-cycle rx valid per byte.
*/
`timescale 1ns/1ps
`default_nettype none
module gprr_rcvr_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  import gprr_pkg::*;
  logic [7:0] got[$];
  int         nfrm = 0;
  logic       in_frm = 1'b0;
  logic       esc = 1'b0;
  initial begin
    tx_ready = 1'b0;
    rx_data  = 8'h5a;
    rx_valid = 1'b0;
  end
  // unframes and unstuffs accepted bytes; stalls every other cycle when slow
  always @(posedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (!in_frm) in_frm = (tx_data == FRAME_DLE);
      else if (esc) begin
        esc = 1'b0;
        if (tx_data == FRAME_ETX) begin
          in_frm = 1'b0;
          nfrm++;
        end else got.push_back(tx_data);
      end else if (tx_data == FRAME_DLE) esc = 1'b1;
      else got.push_back(tx_data);
    end
  end
  // frames a reply with header, trailer and doubled escape bytes
  task automatic send(input logic [7:0] b[$]);
    logic [7:0] s[$];
    s = {FRAME_DLE};
    foreach (b[i]) begin
      s.push_back(b[i]);
      if (b[i] == FRAME_DLE) s.push_back(FRAME_DLE);
    end
    s.push_back(FRAME_DLE);
    s.push_back(FRAME_ETX);
    foreach (s[i]) begin
      @(posedge ref_clk);
      rx_data  <= s[i];
      rx_valid <= 1'b1;
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~s[s.size()-1];
  endtask : send
endmodule : gprr_rcvr_model
`default_nettype wire

/* bench/test_gps_packet_request_relay.sv */
/*
  test_gps_packet_request_relay: directed bench for the relay over apb and the byte link.
  Assumes gprr_pkg and the receiver model; timeout shortened to TO_CYC cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_gps_packet_request_relay;
  import gprr_pkg::*;
  localparam int TO_CYC = 300;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic        tx_valid, tx_ready, rx_valid, pkt_avail, busy, ce;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  tx_data, rx_data;
  logic        e;
  int          error_cnt = 0;
  int          check_count = 0;
  int          pa_cnt = 0;
  logic [7:0]  dflt[$] = '{8'h2c, 8'h04, 8'h3e, 8'h32, 8'hb0, 8'h21, 8'h40, 8'hc0, 8'h00,
    8'h00, 8'h41, 8'h40, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h75, 8'h00,
    8'h35, 8'h03, 8'h03, 8'h00, 8'h00};
  gprr_relay #(.TIMEOUT_CYC_P(TO_CYC)) u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .pkt_avail(pkt_avail), .busy(busy));
  gprr_rcvr_model u_rcv (.ref_clk(ref_clk), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (pkt_avail === 1'b1) pa_cnt++;
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until pready is sampled high or 50 cycles pass
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : apb
  task automatic wreg(input logic [11:0] o, input logic [31:0] d);
    apb(1'b1, {2'b00, RGN_REG, o}, d);
  endtask : wreg
  task automatic wmem(input logic [8:0] i, input logic [7:0] v);
    apb(1'b1, {2'b00, RGN_MEM, 1'b0, i, 2'b00}, {24'h0, v});
  endtask : wmem
  task automatic rmem(input logic [8:0] i);
    apb(1'b0, {2'b00, RGN_MEM, 1'b0, i, 2'b00}, 32'h0);
  endtask : rmem
  task automatic cmd(input logic [7:0] c[$]);
    foreach (c[i]) wmem(9'(i), c[i]);
    wreg(REG_DOORBELL, 32'h1);
  endtask : cmd
  task automatic ack_is(input int b, input logic v);
    apb(1'b0, {2'b00, RGN_REG, REG_ACK}, 32'h0);
    chk(32'(q[b]), 32'(v));
  endtask : ack_is
  task automatic wait_ack(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, {2'b00, RGN_REG, REG_ACK}, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 500);
    chk(32'(q[b]), 32'h1);
  endtask : wait_ack
  task automatic clr_ack;
    wreg(REG_ACK, 32'h7);
    ack_is(ACK_PKT, 1'b0);
  endtask : clr_ack
  task automatic chk_got(input logic [7:0] x[$], input int nf);
    int n;
    n = 0;
    while (u_rcv.nfrm < nf && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(u_rcv.nfrm, nf);
    chk(u_rcv.got.size(), x.size());
    foreach (x[i]) if (i < u_rcv.got.size()) chk(u_rcv.got[i], x[i]);
    u_rcv.got.delete();
    u_rcv.nfrm = 0;
  endtask : chk_got
  task automatic chk_area(input logic [7:0] x[$]);
    foreach (x[i]) begin
      rmem(PKT_BASE + 9'(i));
      chk(q, {24'h0, x[i]});
    end
  endtask : chk_area
  task automatic t_manual;
    int p;
    cmd('{8'h32, 8'h03, 8'h5b, 8'h03, 8'h3b, 8'h10, 8'h06});
    wait_ack(ACK_SENT);
    p = pa_cnt;
    chk_got('{8'h3b, 8'h10, 8'h06}, 1);
    chk(32'(busy), 32'h0000_0001);
    ack_is(ACK_PKT, 1'b0);
    u_rcv.send('{8'h44, 8'h01, 8'h02});
    u_rcv.send('{8'h5b, 8'h10});
    ack_is(ACK_PKT, 1'b0);
    u_rcv.send('{8'h5b, 8'h10, 8'h07});
    wait_ack(ACK_PKT);
    chk_area('{8'h03, 8'h5b, 8'h10, 8'h07});
    chk(pa_cnt, p + 1);
    clr_ack();
    chk(32'(busy), 32'h0000_0000);
  endtask : t_manual
  task automatic t_anylen;
    cmd('{8'h32, 8'h00, 8'h47, 8'h01, 8'h27});
    wait_ack(ACK_SENT);
    chk_got('{8'h27}, 1);
    u_rcv.send('{8'h47, 8'haa, 8'hbb, 8'hcc, 8'hdd});
    wait_ack(ACK_PKT);
    chk_area('{8'h05, 8'h47, 8'haa, 8'hbb, 8'hcc, 8'hdd});
    clr_ack();
  endtask : t_anylen
  task automatic t_noresp;
    cmd('{8'h32, 8'h05, 8'h00, 8'h05, 8'h35, 8'h03, 8'h03, 8'h00, 8'h00});
    wait_ack(ACK_SENT);
    chk_got('{8'h35, 8'h03, 8'h03, 8'h00, 8'h00}, 1);
    repeat (TO_CYC + 50) @(posedge ref_clk);
    ack_is(ACK_PKT, 1'b0);
    chk_area('{8'h00});
    clr_ack();
  endtask : t_noresp
  task automatic t_timeout;
    cmd('{8'h32, 8'h02, 8'h5b, 8'h01, 8'h3b});
    wait_ack(ACK_SENT);
    ack_is(ACK_PKT, 1'b0);
    chk_got('{8'h3b}, 1);
    // a stale length must be overwritten by the timeout, and a frozen timer must not expire
    wmem(PKT_BASE, 8'h55);
    ce <= 1'b0;
    repeat (TO_CYC) @(posedge ref_clk);
    ce <= 1'b1;
    ack_is(ACK_PKT, 1'b0);
    wait_ack(ACK_PKT);
    chk_area('{8'h00});
    clr_ack();
  endtask : t_timeout
  task automatic t_region;
    apb(1'b0, 16'h0000, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 16'h1004, 32'h1);
    chk(32'(e), 32'h1);
    wmem(9'h12c, 8'ha5);
    rmem(9'h12c);
    chk({q[31:1], e}, 32'h0000_00a4);
  endtask : t_region
  task automatic t_tmode;
    slow <= 1'b1;
    wreg(REG_TMODE, 32'h6);
    apb(1'b0, {2'b00, RGN_REG, REG_TMODE}, 32'h0);
    chk(q, 32'h6);
    chk_got(dflt, 3);
  endtask : t_tmode
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    slow = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    chk_got(dflt, 3);
    slow <= 1'b0;
    t_region();
    t_manual();
    t_anylen();
    t_noresp();
    t_timeout();
    t_tmode();
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
endmodule : test_gps_packet_request_relay
`default_nettype wire

/* inc/gprr_pkg.sv */
/*
  gprr_pkg: constants, memory layout, register map, default receiver packets and
  state types of the GPS packet request relay.
  Assumes a 40 MHz card clock and one byte of shared memory per APB word.
*/
`default_nettype none
package gprr_pkg;
  // apb address regions, paddr[13:12]; regions 0 and 1 are reserved
  localparam logic [1:0]  RGN_REG        = 2'h2;
  localparam logic [1:0]  RGN_MEM        = 2'h3;
  // register word offsets inside the register region
  localparam logic [11:0] REG_ACK        = 12'h000;
  localparam logic [11:0] REG_DOORBELL   = 12'h004;
  localparam logic [11:0] REG_TMODE      = 12'h008;
  localparam logic [11:0] REG_STATUS     = 12'h00c;
  // shared memory byte indices: command area, then packet area
  localparam logic [8:0]  CMD_ID_IDX     = 9'h000;
  localparam logic [8:0]  RESP_LEN_IDX   = 9'h001;
  localparam logic [8:0]  RESP_ID_IDX    = 9'h002;
  localparam logic [8:0]  REQ_LEN_IDX    = 9'h003;
  localparam logic [8:0]  REQ_BODY_IDX   = 9'h004;
  localparam logic [8:0]  PKT_BASE       = 9'h100;
  localparam int          MEM_BYTES      = 512;
  localparam logic [7:0]  CMD_MANUAL     = 8'h32;
  localparam logic [7:0]  NO_RESP_ID     = 8'h00;
  localparam logic [7:0]  TMODE_GPS      = 8'h06;
  localparam logic [7:0]  FRAME_DLE      = 8'h10;
  localparam logic [7:0]  FRAME_ETX      = 8'h03;
  localparam logic [7:0]  MAX_LEN        = 8'hff;
  localparam int          ACK_SENT       = 0;
  localparam int          ACK_PKT        = 2;
  localparam logic [2:0]  ACK_RST        = 3'h0;
  localparam logic [7:0]  TMODE_RST      = 8'h00;
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          TIMEOUT_MS     = 3000;
  localparam int          TIMEOUT_CYC    = CLK_HZ / 1000 * TIMEOUT_MS;
  // default packets, {last byte, byte}: operating parameters, high-8 mode, i/o options
  localparam int          ROM_LEN        = 25;
  localparam logic [7:0]  ROM_LAST       = 8'h18;
  localparam logic [8:0]  DFLT_ROM [ROM_LEN] = '{
    9'h02c, 9'h004,                                // id, dynamics static
    9'h03e, 9'h032, 9'h0b0, 9'h021,                // elevation mask 0.1745
    9'h040, 9'h0c0, 9'h000, 9'h000,                // signal level mask 6.0
    9'h041, 9'h040, 9'h000, 9'h000,                // pdop mask 12.0
    9'h041, 9'h000, 9'h000, 9'h100,                // pdop switch 8.0
    9'h075, 9'h100,                                // high-8
    9'h035, 9'h003, 9'h003, 9'h000, 9'h100};       // pos, vel, timing, aux
  typedef enum logic [2:0] {M_IDLE, M_DFLT, M_SEND, M_WAIT, M_POST} gprr_mst_t;
  typedef enum logic [2:0] {T_IDLE, T_HDR, T_BODY, T_STUF, T_TDLE, T_TETX} gprr_tst_t;
  typedef enum logic [1:0] {R_IDLE, R_ID, R_DATA, R_ESC} gprr_rst_t;
endpackage : gprr_pkg
`default_nettype wire

/* rtl/gprr_relay.sv */
/*
  gprr_relay: manual request command engine, default packet sender, framed
  receiver link and apb window onto registers and shared memory.
  Assumes an apb master, a byte link with valid/ready on transmit and a
  one-cycle valid per received byte, all synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: host writes id, response length, response id, request length, request id, data
// RULE2: send the host request packet, copy the matching response into the packet area
// RULE3: response id zero means no wait and no capture, like a plain send
// RULE4: acknowledge bit 0 sets once the request packet has been sent
// RULE5: acknowledge bit 2 sets after the response is fully written
// RULE6: on timeout write zero length, then set acknowledge bit 2
// RULE7: requested length zero accepts any length with a matching identifier
// RULE8: send default packets at reset and on switching to timing mode 6
// RULE9: operating packet: static, 0.1745 mask, 6.0, pdop 12.0, switch 8.0
// RULE10: high-8/high-6 packet carries mode 0
// RULE11: i/o options packet: position 3, velocity 3, timing 0, auxiliary 0
// RULE12: host keeps bits 0 and 1 set in position and velocity options
// RULE13: host keeps timing option bits 0 to 2 clear
// RULE14: registers live in region 2, regions 0 and 1 reserved
// RULE15: byte-wide shared memory lives in region 3
// RULE16: rise of acknowledge bit 2 raises packet available; host clears it (pkt_avail here is a one-cycle pulse that clears itself)
// RULE17: packet area byte 0 length, byte 1 identifier; zero length means none
// RULE18: add framing and stuffing on transmit, strip both on receive
// RULE19: host waits for ack 0 before new commands, ack 2 before reading
// RULE20: drop mismatching packets and keep waiting until match or timeout
module gprr_relay #(
  parameter int TIMEOUT_CYC_P = gprr_pkg::TIMEOUT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             pkt_avail,
  output logic             busy
);
  import gprr_pkg::*;

  logic [31:0]     prdata_ff;
  logic            pready_ff;
  logic            pslverr_ff;
  logic [7:0]      mem_ff [MEM_BYTES];
  logic [2:0]      ack_ff;
  logic [2:0]      nxt_ack;
  logic            go_ff;
  logic [7:0]      tmode_ff;
  logic            dflt_req_ff;
  logic            pkt_avail_ff;
  logic            busy_ff;
  gprr_mst_t       m_st;
  logic [7:0]      resp_len_ff;
  logic [7:0]      resp_id_ff;
  logic [7:0]      req_len_ff;
  logic [31:0]     tmo_ff;
  logic            kick_ff;
  logic            kick_rom_ff;
  logic [7:0]      kick_ptr_ff;
  gprr_tst_t       tx_st;
  logic            tx_rom_ff;
  logic [7:0]      tx_ptr_ff;
  logic [7:0]      tx_data_ff;
  logic            tx_valid_ff;
  gprr_rst_t       rx_st;
  logic            rx_hit_ff;
  logic [7:0]      rx_cnt_ff;
  logic [1:0]      rgn;
  logic            acc_go;
  logic            acc_done;
  logic            set_sent;
  logic            set_pkt;
  logic            tx_acc;
  logic            tx_end;
  logic [7:0]      body_byte;
  logic            body_last;
  logic            rx_end;
  logic            rx_match;
  logic            tmo_hit;
  logic            len_we;
  logic [7:0]      len_wd;
  logic            rx_we;
  logic [8:0]      rx_wa;
  gprr_tst_t       nxt_tx_st;
  logic [7:0]      nxt_tx_ptr;
  logic [7:0]      nxt_tx_data;

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign tx_data   = tx_data_ff;
  assign tx_valid  = tx_valid_ff;
  assign pkt_avail = pkt_avail_ff;
  assign busy      = busy_ff;

  // apb: one wait state, data and error are registered on the same edge as pready
  assign rgn      = paddr[13:12];
  assign acc_go   = psel & penable & ~pready_ff;
  assign acc_done = psel & penable & pready_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff  <= acc_go;
      pslverr_ff <= acc_go & (rgn != RGN_REG) & (rgn != RGN_MEM); // [RULE14]
      if (acc_go && !pwrite) begin
        prdata_ff <= 32'h0000_0000;
        if (rgn == RGN_MEM) begin
          prdata_ff <= {24'h00_0000, mem_ff[paddr[10:2]]}; // [RULE15]
        end else if (rgn == RGN_REG) begin
          case (paddr[11:0])
            REG_ACK:    prdata_ff <= {29'h0000_0000, ack_ff};
            REG_TMODE:  prdata_ff <= {24'h00_0000, tmode_ff};
            REG_STATUS: prdata_ff <= {29'h0000_0000, go_ff, dflt_req_ff, busy_ff};
            default:    prdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // acknowledge bits: hardware set wins over a write-one clear
  always_comb begin
    nxt_ack = ack_ff;
    if (acc_done && pwrite && rgn == RGN_REG && paddr[11:0] == REG_ACK) begin
      nxt_ack = ack_ff & ~pwdata[2:0];
    end
    if (set_sent) begin
      nxt_ack[ACK_SENT] = 1'b1; // [RULE4]
    end
    if (set_pkt) begin
      nxt_ack[ACK_PKT] = 1'b1; // [RULE5] [RULE6]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_ff       <= ACK_RST;
      pkt_avail_ff <= 1'b0;
    end else if (ce) begin
      ack_ff       <= nxt_ack;
      pkt_avail_ff <= nxt_ack[ACK_PKT] & ~ack_ff[ACK_PKT]; // [RULE16]
    end
  end

  // doorbell, timing mode and the pending default request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      go_ff       <= 1'b0;
      tmode_ff    <= TMODE_RST;
      dflt_req_ff <= 1'b1; // [RULE8]
    end else if (ce) begin
      if (m_st == M_IDLE && !dflt_req_ff) begin
        go_ff <= 1'b0;
      end
      if (m_st == M_IDLE && dflt_req_ff) begin
        dflt_req_ff <= 1'b0;
      end
      if (acc_done && pwrite && rgn == RGN_REG) begin
        if (paddr[11:0] == REG_DOORBELL) begin
          go_ff <= 1'b1;
        end
        if (paddr[11:0] == REG_TMODE) begin
          tmode_ff <= pwdata[7:0];
          if (pwdata[7:0] == TMODE_GPS && tmode_ff != TMODE_GPS) begin
            dflt_req_ff <= 1'b1; // [RULE8]
          end
        end
      end
    end
  end

  // shared memory: length byte, then received bytes, then host writes
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (len_we) begin
        mem_ff[PKT_BASE] <= len_wd; // [RULE17]
      end else if (rx_we) begin
        mem_ff[rx_wa] <= rx_data;
      end else if (acc_done && pwrite && rgn == RGN_MEM) begin
        mem_ff[paddr[10:2]] <= pwdata[7:0]; // [RULE15]
      end
    end
  end

  // command sequencer
  assign tmo_hit  = (m_st == M_WAIT) && (tmo_ff == 32'(TIMEOUT_CYC_P - 1));
  assign rx_match = rx_hit_ff && (resp_len_ff == 8'h00 || resp_len_ff == rx_cnt_ff); // [RULE7]
  assign set_sent = (m_st == M_SEND) && !kick_ff && tx_st == T_IDLE; // [RULE4]
  assign set_pkt  = (m_st == M_POST);
  assign len_we   = (m_st == M_IDLE && go_ff && !dflt_req_ff)
                  || (m_st == M_WAIT && (tmo_hit || (rx_end && rx_match)));
  assign len_wd   = (m_st == M_WAIT && !tmo_hit) ? rx_cnt_ff : 8'h00; // [RULE6]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_st        <= M_IDLE;
      kick_ff     <= 1'b0;
      kick_rom_ff <= 1'b0;
      kick_ptr_ff <= 8'h00;
      resp_len_ff <= 8'h00;
      resp_id_ff  <= 8'h00;
      req_len_ff  <= 8'h00;
      busy_ff     <= 1'b0;
    end else if (ce) begin
      kick_ff <= 1'b0;
      busy_ff <= (m_st != M_IDLE);
      case (m_st)
        M_IDLE: begin
          if (dflt_req_ff) begin
            kick_ff     <= 1'b1;
            kick_rom_ff <= 1'b1;
            kick_ptr_ff <= 8'h00;
            m_st        <= M_DFLT;
          end else if (go_ff && mem_ff[CMD_ID_IDX] == CMD_MANUAL
                       && mem_ff[REQ_LEN_IDX] != 8'h00) begin
            resp_len_ff <= mem_ff[RESP_LEN_IDX];
            resp_id_ff  <= mem_ff[RESP_ID_IDX];
            req_len_ff  <= mem_ff[REQ_LEN_IDX];
            kick_ff     <= 1'b1;
            kick_rom_ff <= 1'b0;
            kick_ptr_ff <= 8'h00;
            m_st        <= M_SEND; // [RULE2]
          end
        end
        M_DFLT: begin
          if (!kick_ff && tx_st == T_IDLE) begin
            if (tx_ptr_ff == ROM_LAST) begin
              m_st <= M_IDLE;
            end else begin
              kick_ff     <= 1'b1;
              kick_ptr_ff <= tx_ptr_ff + 8'h01; // [RULE9] [RULE10] [RULE11]
            end
          end
        end
        M_SEND: begin
          if (set_sent) begin
            m_st <= (resp_id_ff == NO_RESP_ID) ? M_IDLE : M_WAIT; // [RULE3]
          end
        end
        M_WAIT: begin
          if (tmo_hit || (rx_end && rx_match)) begin
            m_st <= M_POST; // [RULE20]
          end
        end
        M_POST: m_st <= M_IDLE;
        default: m_st <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tmo_ff <= 32'h0000_0000;
    end else if (ce) begin
      tmo_ff <= (m_st == M_WAIT) ? tmo_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // framed transmitter with stuffing of the escape byte
  always_comb begin
    if (tx_rom_ff) begin
      body_byte = DFLT_ROM[tx_ptr_ff[4:0]][7:0];
      body_last = DFLT_ROM[tx_ptr_ff[4:0]][8];
    end else begin
      body_byte = mem_ff[9'({1'b0, tx_ptr_ff} + REQ_BODY_IDX)];
      body_last = (tx_ptr_ff == req_len_ff - 8'h01);
    end
  end

  assign tx_acc = tx_valid_ff & tx_ready;
  assign tx_end = tx_acc && tx_st == T_TETX;

  always_comb begin
    nxt_tx_st  = tx_st;
    nxt_tx_ptr = tx_ptr_ff;
    if (tx_acc) begin
      case (tx_st)
        T_HDR:   nxt_tx_st = T_BODY;
        T_BODY: begin
          if (body_byte == FRAME_DLE) begin
            nxt_tx_st = T_STUF; // [RULE18]
          end else if (body_last) begin
            nxt_tx_st = T_TDLE;
          end else begin
            nxt_tx_ptr = tx_ptr_ff + 8'h01;
          end
        end
        T_STUF: begin
          nxt_tx_st = body_last ? T_TDLE : T_BODY;
          if (!body_last) begin
            nxt_tx_ptr = tx_ptr_ff + 8'h01;
          end
        end
        T_TDLE:  nxt_tx_st = T_TETX;
        T_TETX:  nxt_tx_st = T_IDLE;
        default: nxt_tx_st = T_IDLE;
      endcase
    end
    case (nxt_tx_st)
      T_BODY:  nxt_tx_data = tx_rom_ff ? DFLT_ROM[nxt_tx_ptr[4:0]][7:0]
                           : mem_ff[9'({1'b0, nxt_tx_ptr} + REQ_BODY_IDX)];
      T_TETX:  nxt_tx_data = FRAME_ETX;
      default: nxt_tx_data = FRAME_DLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st       <= T_IDLE;
      tx_rom_ff   <= 1'b0;
      tx_ptr_ff   <= 8'h00;
      tx_data_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
    end else if (ce) begin
      if (kick_ff) begin
        tx_st       <= T_HDR; // [RULE18]
        tx_rom_ff   <= kick_rom_ff;
        tx_ptr_ff   <= kick_ptr_ff;
        tx_data_ff  <= FRAME_DLE;
        tx_valid_ff <= 1'b1;
      end else begin
        tx_st       <= nxt_tx_st;
        tx_ptr_ff   <= nxt_tx_ptr;
        tx_data_ff  <= nxt_tx_data;
        tx_valid_ff <= (nxt_tx_st != T_IDLE);
      end
    end
  end

  // framed receiver: strips framing and stuffing, stores only a pending match
  assign rx_end = rx_valid && rx_st == R_ESC && rx_data == FRAME_ETX;
  assign rx_we  = rx_valid && !rx_end && m_st == M_WAIT
                && ((rx_st == R_ID && rx_data != FRAME_DLE && rx_data != FRAME_ETX
                     && rx_data == resp_id_ff)
                    || (rx_hit_ff && rx_cnt_ff != MAX_LEN
                        && (rx_st == R_DATA && rx_data != FRAME_DLE
                            || rx_st == R_ESC && rx_data == FRAME_DLE)));
  assign rx_wa  = (rx_st == R_ID) ? PKT_BASE + 9'h001
                : PKT_BASE + 9'h001 + {1'b0, rx_cnt_ff};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st     <= R_IDLE;
      rx_hit_ff <= 1'b0;
      rx_cnt_ff <= 8'h00;
    end else if (ce && rx_valid) begin
      case (rx_st)
        R_IDLE: rx_st <= (rx_data == FRAME_DLE) ? R_ID : R_IDLE;
        R_ID: begin
          if (rx_data == FRAME_DLE || rx_data == FRAME_ETX) begin
            rx_st <= R_IDLE;
          end else begin
            rx_st     <= R_DATA;
            rx_hit_ff <= rx_we; // [RULE2] [RULE20]
            rx_cnt_ff <= 8'h01;
          end
        end
        R_DATA: begin
          if (rx_data == FRAME_DLE) begin
            rx_st <= R_ESC;
          end else if (rx_cnt_ff != MAX_LEN) begin
            rx_cnt_ff <= rx_cnt_ff + 8'h01;
          end else begin
            rx_hit_ff <= 1'b0;
          end
        end
        R_ESC: begin
          if (rx_data == FRAME_DLE) begin
            rx_st     <= R_DATA; // [RULE18]
            rx_cnt_ff <= rx_cnt_ff + 8'h01;
          end else if (rx_data == FRAME_ETX) begin
            rx_st     <= R_IDLE;
            rx_hit_ff <= 1'b0;
          end else begin
            rx_st     <= R_ID;
            rx_hit_ff <= 1'b0;
          end
        end
        default: rx_st <= R_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  sequence s_tmo_fire;
    m_st == M_WAIT && tmo_hit;
  endsequence
  sequence s_zero_then_ack;
    mem_ff[PKT_BASE] == 8'h00 ##1 ack_ff[ACK_PKT];
  endsequence
  property p_timeout_len_zero;
    s_tmo_fire |=> s_zero_then_ack;
  endproperty
  a_timeout_len_zero: assert property (p_timeout_len_zero) else $error("timeout path"); // [RULE6]
  property p_ack0_after_tx;
    tx_end && !tx_rom_ff && m_st == M_SEND |=> ##1 ack_ff[ACK_SENT];
  endproperty
  a_ack0_after_tx: assert property (p_ack0_after_tx) else $error("ack 0 missing"); // [RULE4]
  property p_no_wait_zero_id;
    set_sent && resp_id_ff == NO_RESP_ID |=> m_st == M_IDLE;
  endproperty
  a_no_wait_zero_id: assert property (p_no_wait_zero_id) else $error("waited on id 0"); // [RULE3]
  property p_ack2_after_write;
    $rose(ack_ff[ACK_PKT]) |-> $past(m_st) == M_POST && $past(m_st, 2) == M_WAIT;
  endproperty
  a_ack2_after_write: assert property (p_ack2_after_write) else $error("ack 2 early"); // [RULE5]
  property p_pkt_irq;
    $rose(ack_ff[ACK_PKT]) |-> pkt_avail_ff ##1 !pkt_avail_ff;
  endproperty
  a_pkt_irq: assert property (p_pkt_irq) else $error("packet event wrong"); // [RULE16]
  property p_mode6_defaults;
    acc_done && pwrite && rgn == RGN_REG && paddr[11:0] == REG_TMODE
      && pwdata[7:0] == TMODE_GPS && tmode_ff != TMODE_GPS |=> dflt_req_ff;
  endproperty
  a_mode6_defaults: assert property (p_mode6_defaults) else $error("defaults lost"); // [RULE8]
  property p_static_code;
    tx_valid_ff && tx_rom_ff && tx_st == T_BODY && tx_ptr_ff == 8'h01 |-> tx_data_ff == 8'h04;
  endproperty
  a_static_code: assert property (p_static_code) else $error("bad dynamics"); // [RULE9]
  property p_tx_stuff;
    tx_acc && tx_st == T_BODY && tx_data_ff == FRAME_DLE |=> tx_st == T_STUF && tx_data_ff == FRAME_DLE;
  endproperty
  a_tx_stuff: assert property (p_tx_stuff) else $error("missing stuff byte"); // [RULE18]
  property p_reserved_region;
    acc_go && rgn[1] == 1'b0 |=> pready_ff && pslverr_ff;
  endproperty
  a_reserved_region: assert property (p_reserved_region) else $error("reserved region"); // [RULE14]
  property p_discard;
    m_st == M_WAIT && rx_end && !rx_match && !tmo_hit |=> m_st == M_WAIT;
  endproperty
  a_discard: assert property (p_discard) else $error("mismatch accepted"); // [RULE20]
endmodule : gprr_relay
`default_nettype wire
